/* File: inc/vertex_position_map.vh */
// Constants for the vertex position projection datapath.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef VERTEX_POSITION_MAP_VH
`define VERTEX_POSITION_MAP_VH

// ----------------------------------------------------------------
// Vertex header layout (dword indices)
// ----------------------------------------------------------------
`define HDR_INDEX_W 4
`define HDR_POS_X 4'h4
`define HDR_POS_Y 4'h5
`define HDR_POS_Z 4'h6
`define HDR_POS_W 4'h7

// ----------------------------------------------------------------
// Position space select encodings
// ----------------------------------------------------------------
`define CLIP_SPACE_MODE 1'b0
`define SCREEN_SPACE_MODE 1'b1

// ----------------------------------------------------------------
// Single precision constants
// ----------------------------------------------------------------
`define FP_ONE 32'h3F800000
`define FP_NEG_ONE 32'hBF800000
`define FP_ZERO 32'h00000000
`define FP_QNAN 32'h7FC00000
`define FP_BIAS 10'h07F
`define FP_EXP_MAX 10'h0FF
`define FP_HIDDEN 24'h800000
`define RECIP_EXP_EXACT 10'h0FE
`define RECIP_EXP_INEXACT 10'h0FD

// ----------------------------------------------------------------
// Reciprocal divider and output buffering
// ----------------------------------------------------------------
`define RECIP_STEPS 5'h19
`define RECIP_REM_INIT 26'h1000000
`define CLIP_FLAGS_W 6
`define FIFO_DEPTH 4
`define FIFO_ADDR_W 2
`define OUT_WORD_W 135

`endif

/* File: rtl/vertex_fifo.v */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset, DEPTH a power of two.
`timescale 1ns/1ps

module vertex_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter ADDR_W = 2
) (
    input wire clock,
    input wire reset_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr;
    reg [ADDR_W-1:0] rd_ptr;
    reg [ADDR_W:0] fill;
    wire push;
    wire pop;

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    // Full and empty come straight from the fill count
    assign in_ready = (fill != DEPTH[ADDR_W:0]);
    assign out_valid = (fill != {(ADDR_W+1){1'b0}});
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = store[rd_ptr];

    // Pointers and count; storage itself needs no reset
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= {ADDR_W{1'b0}};
            rd_ptr <= {ADDR_W{1'b0}};
            fill <= {(ADDR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end

    // Write port
    always @(posedge clock) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end
endmodule // vertex_fifo

/* File: rtl/vertex_position_projection.v */
// Clip-stage position datapath: reads the four position dwords of each
// vertex header, projects clip-space positions and clip-tests the result.
// Assumes header dwords arrive one per handshake with their dword index,
// and that the downstream setup stage applies backpressure via out_ready.
`timescale 1ns/1ps
`include "vertex_position_map.vh"

// What this block does
// - One select bit picks clip or screen space; clip test follows that choice.
// - Clip space divides X, Y, Z by W, then clip-tests normalized coordinates.
// - Normalized X, Y, Z are inputs multiplied by the reciprocal of W.
// - Fourth output is reciprocal W, kept for perspective-correct interpolation.
// - Infinity and NaN results pass through all four outputs unaltered.
// - Visible volume is X, Y in [-1,+1]; Z in [-1,+1] or [0,+1].
// - Screen space passes pixel X, Y, mapped Z and reciprocal W, no divide.
// - Position is dwords four to seven of the header: X, Y, Z, W.
module vertex_position_projection (
    input wire clock,
    input wire reset_n,
    input wire position_space_select,
    input wire depth_range_zero_one,
    input wire [31:0] screen_x_max,
    input wire [31:0] screen_y_max,
    input wire in_valid,
    output wire in_ready,
    input wire [`HDR_INDEX_W-1:0] in_dword_index,
    input wire [31:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [31:0] out_pos_x,
    output wire [31:0] out_pos_y,
    output wire [31:0] out_pos_z,
    output wire [31:0] out_reciprocal_w,
    output wire [`CLIP_FLAGS_W-1:0] out_clip_flags,
    output wire out_screen_space
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [3:0] ST_GATHER = 4'h1;
    localparam [3:0] ST_RECIP = 4'h2;
    localparam [3:0] ST_MUL = 4'h4;
    localparam [3:0] ST_PUSH = 4'h8;

    reg [3:0] state;
    reg [31:0] pos_x;
    reg [31:0] pos_y;
    reg [31:0] pos_z;
    reg [31:0] pos_w;
    reg mode;
    reg [31:0] res_x;
    reg [31:0] res_y;
    reg [31:0] res_z;
    reg [31:0] res_w;
    reg [24:0] quot;
    reg [25:0] rem;
    reg [4:0] step;
    reg [1:0] mul_sel;

    wire [23:0] w_mant;
    wire [25:0] rem_diff;
    wire quot_bit;
    wire [31:0] recip_value;
    reg [31:0] mul_a;
    wire [31:0] mul_result;
    wire [31:0] x_lo_bound;
    wire [31:0] x_hi_bound;
    wire [31:0] y_lo_bound;
    wire [31:0] y_hi_bound;
    wire [31:0] z_lo_bound;
    wire [`CLIP_FLAGS_W-1:0] clip_flags;
    wire fifo_in_ready;
    wire [`OUT_WORD_W-1:0] fifo_in_data;
    wire [`OUT_WORD_W-1:0] fifo_out_data;
    wire take;

    // ------------------------------------------------------------
    // Float helpers
    // ------------------------------------------------------------
    // Round to nearest even and pack; denormal results flush to zero
    function [31:0] fp_pack;
        input s;
        input [9:0] e;
        input [23:0] m;
        input g;
        input st;
        reg [24:0] r;
        reg [23:0] m2;
        reg [9:0] e2;
        begin
            r = {1'b0, m} + {24'h000000, g & (st | m[0])};
            if (r[24]) begin
                m2 = r[24:1];
                e2 = e + 10'h001;
            end else begin
                m2 = r[23:0];
                e2 = e;
            end
            if (e2[9] || e2 == 10'h000) begin
                fp_pack = {s, 31'h00000000};
            end else if (e2 >= `FP_EXP_MAX) begin
                fp_pack = {s, 8'hFF, 23'h000000};
            end else begin
                fp_pack = {s, e2[7:0], m2[22:0]};
            end
        end
    endfunction

    // Single precision multiply with the usual special cases
    function [31:0] fp_mul;
        input [31:0] a;
        input [31:0] b;
        reg s;
        reg a_nan;
        reg b_nan;
        reg a_inf;
        reg b_inf;
        reg a_zero;
        reg b_zero;
        reg [47:0] p;
        reg [9:0] e;
        begin
            s = a[31] ^ b[31];
            a_nan = (a[30:23] == 8'hFF) && (a[22:0] != 23'h000000);
            b_nan = (b[30:23] == 8'hFF) && (b[22:0] != 23'h000000);
            a_inf = (a[30:23] == 8'hFF) && (a[22:0] == 23'h000000);
            b_inf = (b[30:23] == 8'hFF) && (b[22:0] == 23'h000000);
            a_zero = (a[30:23] == 8'h00);
            b_zero = (b[30:23] == 8'h00);
            p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
            e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - `FP_BIAS;
            // Exponent sum below the bias wraps to a set sign bit: underflow
            if ({2'b00, a[30:23]} + {2'b00, b[30:23]} < `FP_BIAS) begin
                e = 10'h200;
            end
            if (a_nan || b_nan || (a_inf && b_zero) || (a_zero && b_inf)) begin
                fp_mul = `FP_QNAN;
            end else if (a_inf || b_inf) begin
                fp_mul = {s, 8'hFF, 23'h000000};
            end else if (a_zero || b_zero) begin
                fp_mul = {s, 31'h00000000};
            end else if (p[47]) begin
                fp_mul = fp_pack(s, e + 10'h001, p[47:24], p[23], |p[22:0]);
            end else begin
                fp_mul = fp_pack(s, e, p[46:23], p[22], |p[21:0]);
            end
        end
    endfunction

    // Order-preserving key; both zeros map to the same key
    function [31:0] fp_key;
        input [31:0] a;
        begin
            if (a[30:0] == 31'h00000000) begin
                fp_key = 32'h80000000;
            end else if (a[31]) begin
                fp_key = ~a;
            end else begin
                fp_key = {1'b1, a[30:0]};
            end
        end
    endfunction

    function fp_is_nan;
        input [31:0] a;
        begin
            fp_is_nan = (a[30:23] == 8'hFF) && (a[22:0] != 23'h000000);
        end
    endfunction

    // Outside test; a NaN coordinate counts as outside both planes
    function fp_below;
        input [31:0] a;
        input [31:0] bound;
        begin
            fp_below = fp_is_nan(a) || (fp_key(a) < fp_key(bound));
        end
    endfunction

    // ------------------------------------------------------------
    // Reciprocal of W: restoring divider, one quotient bit per cycle
    // ------------------------------------------------------------
    // A zero or denormal W uses the hidden bit alone so the divider never sees 0
    assign w_mant = (pos_w[30:23] == 8'h00) ? `FP_HIDDEN : {1'b1, pos_w[22:0]};
    assign rem_diff = rem - {2'b00, w_mant};
    assign quot_bit = (rem >= {2'b00, w_mant});

    // Special W values override the divider result
    assign recip_value =
        fp_is_nan(pos_w) ? `FP_QNAN :
        (pos_w[30:23] == 8'hFF) ? {pos_w[31], 31'h00000000} :
        (pos_w[30:23] == 8'h00) ? {pos_w[31], 8'hFF, 23'h000000} :
        (pos_w[22:0] == 23'h000000) ?
            fp_pack(pos_w[31], `RECIP_EXP_EXACT - {2'b00, pos_w[30:23]}, `FP_HIDDEN, 1'b0, 1'b0) :
            fp_pack(pos_w[31], `RECIP_EXP_INEXACT - {2'b00, pos_w[30:23]}, quot[24:1], quot[0],
                    rem != 26'h0000000);

    // ------------------------------------------------------------
    // Shared multiplier, one component per cycle
    // ------------------------------------------------------------
    // One multiplier reused three times trades latency for area
    always @* begin
        case (mul_sel)
            2'h0: mul_a = pos_x;
            2'h1: mul_a = pos_y;
            default: mul_a = pos_z;
        endcase
    end
    assign mul_result = fp_mul(mul_a, recip_value);

    // ------------------------------------------------------------
    // Clip test bounds per coordinate space
    // ------------------------------------------------------------
    assign x_lo_bound = (mode == `SCREEN_SPACE_MODE) ? `FP_ZERO : `FP_NEG_ONE;
    assign x_hi_bound = (mode == `SCREEN_SPACE_MODE) ? screen_x_max : `FP_ONE;
    assign y_lo_bound = x_lo_bound;
    assign y_hi_bound = (mode == `SCREEN_SPACE_MODE) ? screen_y_max : `FP_ONE;
    // Screen space Z is already in depth-test range, so [0,+1]
    assign z_lo_bound = ((mode == `SCREEN_SPACE_MODE) || depth_range_zero_one) ? `FP_ZERO : `FP_NEG_ONE;

    // Flags: x low, x high, y low, y high, z low, z high
    assign clip_flags = {
        fp_below(`FP_ONE, res_z) || fp_is_nan(res_z),
        fp_below(res_z, z_lo_bound),
        fp_below(y_hi_bound, res_y) || fp_is_nan(res_y),
        fp_below(res_y, y_lo_bound),
        fp_below(x_hi_bound, res_x) || fp_is_nan(res_x),
        fp_below(res_x, x_lo_bound)
    };

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    assign in_ready = state[0];
    assign take = in_valid && state[0];

    // Sequencer and position capture
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_GATHER;
            pos_x <= `FP_ZERO;
            pos_y <= `FP_ZERO;
            pos_z <= `FP_ZERO;
            pos_w <= `FP_ONE;
            mode <= `CLIP_SPACE_MODE;
            res_x <= `FP_ZERO;
            res_y <= `FP_ZERO;
            res_z <= `FP_ZERO;
            res_w <= `FP_ONE;
            quot <= 25'h0000000;
            rem <= 26'h0000000;
            step <= 5'h00;
            mul_sel <= 2'h0;
        end else begin
            case (state)
                ST_GATHER: begin
                    if (take) begin
                        // Other header dwords are accepted and dropped
                        case (in_dword_index)
                            `HDR_POS_X: pos_x <= in_data;
                            `HDR_POS_Y: pos_y <= in_data;
                            `HDR_POS_Z: pos_z <= in_data;
                            `HDR_POS_W: begin
                                pos_w <= in_data;
                                mode <= position_space_select;
                                if (position_space_select == `SCREEN_SPACE_MODE) begin
                                    // Already mapped, so no divide at all
                                    res_x <= pos_x;
                                    res_y <= pos_y;
                                    res_z <= pos_z;
                                    res_w <= in_data;
                                    state <= ST_PUSH;
                                end else begin
                                    rem <= `RECIP_REM_INIT;
                                    quot <= 25'h0000000;
                                    step <= 5'h00;
                                    state <= ST_RECIP;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_RECIP: begin
                    quot <= {quot[23:0], quot_bit};
                    rem <= quot_bit ? {rem_diff[24:0], 1'b0} : {rem[24:0], 1'b0};
                    step <= step + 5'h01;
                    if (step == `RECIP_STEPS - 5'h01) begin
                        mul_sel <= 2'h0;
                        state <= ST_MUL;
                    end
                end
                ST_MUL: begin
                    mul_sel <= mul_sel + 2'h1;
                    case (mul_sel)
                        2'h0: res_x <= mul_result;
                        2'h1: res_y <= mul_result;
                        default: begin
                            res_z <= mul_result;
                            res_w <= recip_value;
                            state <= ST_PUSH;
                        end
                    endcase
                end
                ST_PUSH: begin
                    // Waits here while the output buffer is full
                    if (fifo_in_ready) begin
                        state <= ST_GATHER;
                    end
                end
                default: state <= ST_GATHER;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output buffer toward the setup stage
    // ------------------------------------------------------------
    assign fifo_in_data = {mode, clip_flags, res_w, res_z, res_y, res_x};

    vertex_fifo #(
        .WIDTH(`OUT_WORD_W),
        .DEPTH(`FIFO_DEPTH),
        .ADDR_W(`FIFO_ADDR_W)
    ) u_out_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(state[3]),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out_data)
    );

    assign out_pos_x = fifo_out_data[31:0];
    assign out_pos_y = fifo_out_data[63:32];
    assign out_pos_z = fifo_out_data[95:64];
    assign out_reciprocal_w = fifo_out_data[127:96];
    assign out_clip_flags = fifo_out_data[133:128];
    assign out_screen_space = fifo_out_data[134];
endmodule // vertex_position_projection

/* File: verification/projection_checker.sv */
// Concurrent checks on the projection datapath ports.
// Assumes binding to the top module; one clock, async active-low reset.
`timescale 1ns/1ps
`include "vertex_position_map.vh"

module projection_checker (
    input wire clock,
    input wire reset_n,
    input wire position_space_select,
    input wire depth_range_zero_one,
    input wire [31:0] screen_x_max,
    input wire [31:0] screen_y_max,
    input wire in_valid,
    input wire in_ready,
    input wire [`HDR_INDEX_W-1:0] in_dword_index,
    input wire [31:0] in_data,
    input wire out_valid,
    input wire out_ready,
    input wire [31:0] out_pos_x,
    input wire [31:0] out_pos_y,
    input wire [31:0] out_pos_z,
    input wire [31:0] out_reciprocal_w,
    input wire [`CLIP_FLAGS_W-1:0] out_clip_flags,
    input wire out_screen_space
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [31:0] wx, wy, wz, sx, sy, sz, sw;
    wire take = in_valid && in_ready;
    wire close = take && in_dword_index == `HDR_POS_W;
    // Snapshot frozen at the closing dword so the next vertex cannot disturb it
    always @(posedge clock) begin
        if (take && in_dword_index == `HDR_POS_X) wx <= in_data;
        if (take && in_dword_index == `HDR_POS_Y) wy <= in_data;
        if (take && in_dword_index == `HDR_POS_Z) wz <= in_data;
        if (close) begin
            sx <= wx;
            sy <= wy;
            sz <= wz;
            sw <= in_data;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // Closing dword with an empty output buffer, so the vertex shows at the head
    sequence s_scr_close; close && position_space_select && !out_valid; endsequence
    sequence s_clip_close; close && !position_space_select && !out_valid; endsequence
    property p_ready_drop; close |=> !in_ready; endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("in_ready high after closing dword");
    property p_divide_busy; s_clip_close |=> (!in_ready) [*8]; endproperty
    a_divide_busy: assert property (p_divide_busy)
        else $error("in_ready back during divide");
    property p_scr_pass;
        s_scr_close |-> ##[1:3] (out_valid && out_screen_space && out_pos_x == sx && out_pos_y == sy
            && out_pos_z == sz && out_reciprocal_w == sw);
    endproperty
    a_scr_pass: assert property (p_scr_pass)
        else $error("screen vertex not passed through");
    property p_unit_w;
        s_clip_close ##0 in_data == `FP_ONE |-> ##[28:34] (out_valid && !out_screen_space
            && out_pos_x == sx && out_reciprocal_w == `FP_ONE);
    endproperty
    a_unit_w: assert property (p_unit_w)
        else $error("unit W result wrong");
    property p_zero_w;
        s_clip_close ##0 in_data[30:0] == 31'h0 |-> ##[28:34] (out_valid
            && out_reciprocal_w == {sw[31], 31'h7F800000});
    endproperty
    a_zero_w: assert property (p_zero_w)
        else $error("zero W not signed infinity");
    property p_nan_w;
        s_clip_close ##0 (in_data[30:23] == 8'hFF && in_data[22:0] != 23'h0) |-> ##[28:34] (out_valid
            && out_reciprocal_w == `FP_QNAN && out_pos_x == `FP_QNAN);
    endproperty
    a_nan_w: assert property (p_nan_w)
        else $error("NaN W not carried");
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_pos_x) && $stable(out_reciprocal_w)
            && $stable(out_clip_flags);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output changed while stalled");
    property p_x_low; out_valid && out_pos_x[31] && out_pos_x[30:0] > 31'h3F800000 |-> out_clip_flags[0]; endproperty
    a_x_low: assert property (p_x_low)
        else $error("x below bound not flagged");
    property p_x_in;
        out_valid && !out_screen_space && out_pos_x[30:0] <= 31'h3F800000 |-> out_clip_flags[1:0] == 2'b00;
    endproperty
    a_x_in: assert property (p_x_in)
        else $error("x inside bound flagged");
    property p_z_zero_one;
        out_valid && !out_screen_space && depth_range_zero_one && out_pos_z[31] && out_pos_z[30:0] != 31'h0
            && out_pos_z[30:0] <= 31'h3F800000 |-> out_clip_flags[4];
    endproperty
    a_z_zero_one: assert property (p_z_zero_one)
        else $error("negative z not flagged in zero-one range");
endmodule // projection_checker

bind vertex_position_projection projection_checker u_projection_checker (
    .clock(clock), .reset_n(reset_n), .position_space_select(position_space_select),
    .depth_range_zero_one(depth_range_zero_one), .screen_x_max(screen_x_max), .screen_y_max(screen_y_max),
    .in_valid(in_valid), .in_ready(in_ready), .in_dword_index(in_dword_index), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_pos_x(out_pos_x), .out_pos_y(out_pos_y),
    .out_pos_z(out_pos_z), .out_reciprocal_w(out_reciprocal_w), .out_clip_flags(out_clip_flags),
    .out_screen_space(out_screen_space));

/* File: verification/setup_stage_sink.sv */
// Downstream setup-stage stand-in: accepts output words and queues them.
// Assumes the bench sets its pace: hold never accepts, slow accepts one in four.
`timescale 1ns/1ps

module setup_stage_sink (
    input wire clock,
    input wire reset_n,
    input wire hold,
    input wire slow,
    input wire out_valid,
    output logic out_ready,
    input wire [31:0] pos_x,
    input wire [31:0] pos_y,
    input wire [31:0] pos_z,
    input wire [31:0] recip_w,
    input wire [5:0] flags,
    input wire screen
);
    logic [1:0] pace;
    logic [134:0] q[$];
    // Ready from a flop, so it only moves just after an edge
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pace <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            pace <= pace + 2'h1;
            out_ready <= !hold && (!slow || pace == 2'h3);
        end
    end
    // No space bit of its own: every word is taken as it comes, X Y Z W order
    always @(posedge clock) begin
        if (reset_n && out_valid && out_ready) begin
            q.push_back({flags, screen, pos_x, pos_y, pos_z, recip_w});
        end
    end
endmodule // setup_stage_sink

/* File: verification/tb_vertex_position_projection.sv */
// Self-checking bench for the projection datapath; tasks play the upstream stage.
// Assumes the sink model queues popped words for comparison.
`timescale 1ns/1ps

module tb_vertex_position_projection;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic sel = 1'b0;
    logic zo = 1'b1;
    logic in_valid = 1'b0;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [31:0] din = 32'h0;
    logic [31:0] xmax = 32'h44200000;
    logic [31:0] ymax = 32'h43F00000;
    logic [31:0] px, py, pz, pw;
    logic [5:0] fl;
    logic out_valid, out_ready, scr, in_ready;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    vertex_position_projection u_vertex_position_projection (.clock(clock), .reset_n(reset_n),
        .position_space_select(sel), .depth_range_zero_one(zo), .screen_x_max(xmax), .screen_y_max(ymax),
        .in_valid(in_valid), .in_ready(in_ready), .in_dword_index(idx), .in_data(din),
        .out_valid(out_valid), .out_ready(out_ready), .out_pos_x(px), .out_pos_y(py), .out_pos_z(pz),
        .out_reciprocal_w(pw), .out_clip_flags(fl), .out_screen_space(scr));
    setup_stage_sink u_setup_stage_sink (.clock(clock), .reset_n(reset_n), .hold(hold), .slow(slow),
        .out_valid(out_valid), .out_ready(out_ready), .pos_x(px), .pos_y(py), .pos_z(pz),
        .recip_w(pw), .flags(fl), .screen(scr));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task print_verdict;
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Offer one dword and hold it until the edge that takes it
    task put(input logic [3:0] i, input logic [31:0] d);
        int n;
        n = 0;
        idx = i;
        din = d;
        in_valid = 1'b1;
        while (in_ready !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (in_ready !== 1'b1) error_cnt++;
        @(posedge clock);
        #1;
    endtask
    // Dword 7 last, since screen mode copies X, Y, Z when it is taken
    task vtx(input logic s, input logic [31:0] x, y, z, w);
        @(posedge clock);
        #1;
        sel = s;
        put(4'h4, x);
        put(4'h5, y);
        put(4'h6, z);
        put(4'h2, 32'hDEADBEEF);
        put(4'h7, w);
        in_valid = 1'b0;
    endtask
    task pop(input logic [31:0] x, y, z, w, input logic [5:0] f, input logic s);
        int n;
        logic [134:0] v;
        n = 0;
        while (u_setup_stage_sink.q.size() == 0 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        v = 'x;
        if (u_setup_stage_sink.q.size() > 0) v = u_setup_stage_sink.q.pop_front();
        chk("pos_x", x, v[127:96]);
        chk("pos_y", y, v[95:64]);
        chk("pos_z", z, v[63:32]);
        chk("reciprocal_w", w, v[31:0]);
        chk("clip_flags", {26'h0, f}, {26'h0, v[134:129]});
        chk("screen_space", {31'h0, s}, {31'h0, v[128]});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_screen;
        vtx(1'b1, 32'h42C80000, 32'h42480000, 32'h3F000000, 32'h3E800000);
        vtx(1'b1, 32'hC0000000, 32'h447A0000, 32'h40000000, 32'h3F800000);
        pop(32'h42C80000, 32'h42480000, 32'h3F000000, 32'h3E800000, 6'h00, 1'b1);
        pop(32'hC0000000, 32'h447A0000, 32'h40000000, 32'h3F800000, 6'h29, 1'b1);
    endtask
    task t_clip;
        vtx(1'b0, 32'h3F800000, 32'hC0800000, 32'hBF800000, 32'h40000000);
        vtx(1'b0, 32'h3F400000, 32'h3E800000, 32'h3F000000, 32'h3F800000);
        pop(32'h3F000000, 32'hC0000000, 32'hBF000000, 32'h3F000000, 6'h14, 1'b0);
        pop(32'h3F400000, 32'h3E800000, 32'h3F000000, 32'h3F800000, 6'h00, 1'b0);
        zo = 1'b0;
        vtx(1'b0, 32'h3F800000, 32'hC0800000, 32'hBF800000, 32'h40000000);
        pop(32'h3F000000, 32'hC0000000, 32'hBF000000, 32'h3F000000, 6'h04, 1'b0);
    endtask
    task t_special;
        vtx(1'b0, 32'h3F800000, 32'hBF800000, 32'h00000000, 32'h00000000);
        pop(32'h7F800000, 32'hFF800000, 32'h7FC00000, 32'h7F800000, 6'h36, 1'b0);
        vtx(1'b0, 32'h3F800000, 32'hBF800000, 32'h00000000, 32'h80000000);
        pop(32'hFF800000, 32'h7F800000, 32'h7FC00000, 32'hFF800000, 6'h39, 1'b0);
        vtx(1'b0, 32'h3F800000, 32'hBF800000, 32'h00000000, 32'h7FC00000);
        pop(32'h7FC00000, 32'h7FC00000, 32'h7FC00000, 32'h7FC00000, 6'h3F, 1'b0);
    endtask
    // Five vertices into a stalled sink; all drain in order
    task t_full;
        hold = 1'b1;
        for (int i = 0; i < 5; i++) vtx(1'b1, 32'h3F800000 | (i << 16), 32'h0, 32'h0, 32'h3F800000);
        repeat (3) @(posedge clock);
        #1;
        chk("in_ready", 32'h0, {31'h0, in_ready});
        hold = 1'b0;
        slow = 1'b1;
        for (int i = 0; i < 5; i++) pop(32'h3F800000 | (i << 16), 32'h0, 32'h0, 32'h3F800000, 6'h00, 1'b1);
        slow = 1'b0;
    endtask

    initial begin
        forever #10 clock = ~clock;
    end
    // Hang guard, far above the scenarios' needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict;
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        #1;
        reset_n = 1'b1;
        chk("in_ready", 32'h1, {31'h0, in_ready});
        chk("out_valid", 32'h0, {31'h0, out_valid});
        t_screen;
        t_clip;
        t_special;
        t_full;
        print_verdict;
    end
endmodule // tb_vertex_position_projection
